// ---- hw/fifo_ctl_cfg.svh ----
`ifndef FIFO_CTL_CFG_SVH
`define FIFO_CTL_CFG_SVH

// Word indices of the control registers
`define REG_FILL      3'h0
`define REG_LIVE      3'h1
`define REG_STICKY    3'h2
`define REG_MASK      3'h3
`define REG_HIGH      3'h4
`define REG_LOW       3'h5

// Bit positions shared by live flags, sticky flags and mask
`define BIT_EMPTY     0
`define BIT_FULL      1
`define BIT_LOW_MARK  2
`define BIT_HIGH_MARK 3
`define BIT_OVERRUN   4
`define BIT_UNDERRUN  5
`define BIT_ALL       6
`define FLAG_COUNT    6

// Storage depth of the FIFO served by this block, in words
`define FIFO_DEPTH    32'h0000_0100
// Set for the dual-clock build, clear for the single-clock build
`define DUAL_CLOCK    1'h1
`define GAP_DUAL      32'h0000_0004
`define GAP_SINGLE    32'h0000_0001
`define MARK_MIN      32'h0000_0001

// Reset values
`define FLAGS_RESET   6'h00
`define MASK_RESET    7'h00
`define WORD_ZERO     32'h0000_0000

`endif

// ---- hw/fifo_ctl_pkg.sv ----
package fifo_ctl_pkg;
	typedef logic [5:0]  flags_t;
	typedef logic [6:0]  mask_t;
	typedef logic [31:0] word_t;
	typedef logic [2:0]  reg_addr_t;
endpackage

// ---- hw/fifo_status_event_irq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_cfg.svh"

// Contract
// R01: Sticky bit 1 sets once the FIFO has been full and holds until cleared.
// R02: Sticky bit 0 sets once the FIFO has been empty and holds until cleared.
// R03: Sticky bit 3 sets once the fill exceeded the high mark, held till cleared.
// R04: Sticky bit 2 sets once the fill fell below the low mark, held till cleared.
// R05: Sticky bit 4 sets after any overrun and holds until cleared.
// R06: Sticky bit 5 sets after any underrun and holds until cleared.
// R07: An enabled sticky bit going from zero to one interrupts the master.
// R08: Mask bits use the sticky bit positions 0 to 5.
// R09: Mask bit 6 lets all six conditions interrupt regardless of the rest.
// R10: A write into the full FIFO counts as an overrun.
// R11: A read from the empty FIFO counts as an underrun.
// R12: Software clears the sticky bits, then writes the mask, then the marks.
// R13: Each sticky bit sets whenever its live status bit is set.
// R14: A sticky bit clears only when software writes a one to its position.
// R15: High mark writes are clamped between one and the variant default.
// R16: Writing zero leaves a sticky bit alone; reads have no side effect.
// R17: After reset all sticky and mask bits are zero; the code sets sticky bits 0 and 2 (empty, low mark) on the first clock.
module fifo_status_event_irq (
	input  wire logic                   clk_in,
	input  wire logic                   nrst_in,
	input  wire fifo_ctl_pkg::word_t    fill_level_in,
	input  wire logic                   fifo_wr_in,
	input  wire logic                   fifo_rd_in,
	input  wire fifo_ctl_pkg::reg_addr_t addr_in,
	input  wire logic                   rd_in,
	input  wire logic                   wr_in,
	input  wire fifo_ctl_pkg::word_t    wdata_in,
	output var  fifo_ctl_pkg::word_t    rdata_out,
	output var  fifo_ctl_pkg::flags_t   live_flags_out,
	output var  logic                   irq_out
);
	import fifo_ctl_pkg::*;

	localparam word_t HIGH_MAX = (`DUAL_CLOCK) ?
		(`FIFO_DEPTH - `GAP_DUAL) : (`FIFO_DEPTH - `GAP_SINGLE);

	flags_t live;
	flags_t sticky_flags;
	flags_t clr;
	mask_t  irq_mask;
	word_t  high_watermark;
	word_t  low_watermark;
	flags_t live_flags;
	mask_t  next_irq_mask;
	word_t  next_high;
	word_t  next_low;
	word_t  next_rdata;
	flags_t next_live;
	logic   next_irq;

	// Register select, used by every write path
	function automatic logic sel(input reg_addr_t a, input reg_addr_t r);
		sel = wr_in && (a == r);
	endfunction

	// Clamp a written mark into the legal band
	function automatic word_t clamp(input word_t v);
		if (v < `MARK_MIN) begin
			clamp = `MARK_MIN;
		end else if (v > HIGH_MAX) begin
			clamp = HIGH_MAX;
		end else begin
			clamp = v;
		end
	endfunction

	// Instantaneous conditions; same clock as the FIFO, so no sync
	always_comb begin
		live = `FLAGS_RESET;
		live[`BIT_FULL]      = (fill_level_in >= `FIFO_DEPTH);     // [R01]
		live[`BIT_EMPTY]     = (fill_level_in == `WORD_ZERO);      // [R02]
		live[`BIT_HIGH_MARK] = (fill_level_in > high_watermark);   // [R03]
		live[`BIT_LOW_MARK]  = (fill_level_in < low_watermark);    // [R04]
		live[`BIT_OVERRUN]   = fifo_wr_in && live[`BIT_FULL];  // [R05] [R10]
		live[`BIT_UNDERRUN]  = fifo_rd_in && live[`BIT_EMPTY]; // [R06] [R11]
	end

	// Write-one-to-clear strobes; zeros leave bits alone
	always_comb begin
		clr = sel(addr_in, `REG_STICKY) ?
			wdata_in[`FLAG_COUNT-1:0] : `FLAGS_RESET; // [R14] [R16]
	end

	// Sticky bits follow their live status bits
	genvar g;
	generate
		for (g = 0; g < `FLAG_COUNT; g++) begin : g_sticky
			sticky_flag u_flag (
				.clk_in   (clk_in),
				.nrst_in  (nrst_in),
				.set_in   (live[g]),         // [R13]
				.clr_in   (clr[g]),
				.flag_out (sticky_flags[g])
			);
		end
	endgenerate

	// Writable control registers
	always_comb begin
		next_irq_mask = irq_mask;
		next_high     = high_watermark;
		next_low      = low_watermark;
		if (sel(addr_in, `REG_MASK)) begin
			next_irq_mask = wdata_in[`BIT_ALL:0];          // [R08]
		end
		if (sel(addr_in, `REG_HIGH)) begin
			next_high = clamp(wdata_in);                    // [R15]
		end
		if (sel(addr_in, `REG_LOW)) begin
			// Low mark may not pass the largest legal high mark
			next_low = clamp(wdata_in);
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_mask       <= `MASK_RESET;                 // [R17]
			high_watermark <= HIGH_MAX;
			low_watermark  <= `MARK_MIN;
		end else begin
			irq_mask       <= next_irq_mask;
			high_watermark <= next_high;
			low_watermark  <= next_low;
		end
	end

	// Read data; reading never disturbs any state
	always_comb begin
		next_rdata = `WORD_ZERO;
		if (rd_in) begin
			unique case (addr_in)
				`REG_FILL:   next_rdata = fill_level_in;
				`REG_LIVE:   next_rdata[`FLAG_COUNT-1:0] = live_flags;
				`REG_STICKY: next_rdata[`FLAG_COUNT-1:0] = sticky_flags; // [R16]
				`REG_MASK:   next_rdata[`BIT_ALL:0] = irq_mask;
				`REG_HIGH:   next_rdata = high_watermark;
				`REG_LOW:    next_rdata = low_watermark;
				default:     next_rdata = `WORD_ZERO;
			endcase
		end
	end

	// Interrupt: a level while any enabled sticky bit is set, so every
	// zero-to-one change of an enabled bit is seen by the master
	always_comb begin
		next_live = live;
		next_irq  = irq_mask[`BIT_ALL] ? (|sticky_flags) :       // [R09]
			(|(sticky_flags & irq_mask[`FLAG_COUNT-1:0]));   // [R07]
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out  <= `WORD_ZERO;
			live_flags <= `FLAGS_RESET;
			irq_out    <= 1'h0;
		end else begin
			rdata_out  <= next_rdata;
			live_flags <= next_live;
			irq_out    <= next_irq;
		end
	end

	assign live_flags_out = live_flags;

	// Checks

	sequence s_overrun;
		fifo_wr_in && (fill_level_in >= `FIFO_DEPTH);
	endsequence

	sequence s_underrun;
		fifo_rd_in && (fill_level_in == `WORD_ZERO);
	endsequence

	property p_full_sets;
		@(posedge clk_in) disable iff (!nrst_in)
		(fill_level_in >= `FIFO_DEPTH) |=> sticky_flags[`BIT_FULL];
	endproperty
	a_full_sets: assert property (p_full_sets) // [R01]
		else $error("full did not set sticky bit");

	property p_empty_sets;
		@(posedge clk_in) disable iff (!nrst_in)
		(fill_level_in == `WORD_ZERO) |=> sticky_flags[`BIT_EMPTY];
	endproperty
	a_empty_sets: assert property (p_empty_sets) // [R02]
		else $error("empty did not set sticky bit");

	property p_high_sets;
		@(posedge clk_in) disable iff (!nrst_in)
		(fill_level_in > high_watermark) |=>
			sticky_flags[`BIT_HIGH_MARK] && live_flags[`BIT_HIGH_MARK];
	endproperty
	a_high_sets: assert property (p_high_sets) // [R03]
		else $error("high mark did not set sticky bit");

	property p_low_sets;
		@(posedge clk_in) disable iff (!nrst_in)
		(fill_level_in < low_watermark) |=> sticky_flags[`BIT_LOW_MARK];
	endproperty
	a_low_sets: assert property (p_low_sets) // [R04]
		else $error("low mark did not set sticky bit");

	property p_overrun;
		@(posedge clk_in) disable iff (!nrst_in)
		s_overrun |=> sticky_flags[`BIT_OVERRUN] && live_flags[`BIT_OVERRUN];
	endproperty
	a_overrun: assert property (p_overrun) // [R05]
		else $error("overrun not latched");

	property p_underrun;
		@(posedge clk_in) disable iff (!nrst_in)
		s_underrun |=> sticky_flags[`BIT_UNDERRUN];
	endproperty
	a_underrun: assert property (p_underrun) // [R06]
		else $error("underrun not latched");

	property p_irq_enabled;
		@(posedge clk_in) disable iff (!nrst_in)
		$rose(|(sticky_flags & irq_mask[`FLAG_COUNT-1:0])) |=> irq_out;
	endproperty
	a_irq_enabled: assert property (p_irq_enabled) // [R07]
		else $error("enabled event did not interrupt");

	property p_irq_all;
		@(posedge clk_in) disable iff (!nrst_in)
		(irq_mask[`BIT_ALL] && (|sticky_flags)) |=> irq_out;
	endproperty
	a_irq_all: assert property (p_irq_all) // [R09]
		else $error("all-enable did not interrupt");

	property p_irq_cause;
		@(posedge clk_in) disable iff (!nrst_in)
		irq_out |-> $past(|sticky_flags);
	endproperty
	a_irq_cause: assert property (p_irq_cause) // [R07]
		else $error("interrupt without event");

	property p_clear_only_w1c;
		@(posedge clk_in) disable iff (!nrst_in)
		((($past(sticky_flags) & ~sticky_flags) & ~$past(clr)) ==
			`FLAGS_RESET);
	endproperty
	a_clear_only_w1c: assert property (p_clear_only_w1c) // [R14]
		else $error("sticky bit cleared without a one written");

	property p_read_quiet;
		@(posedge clk_in) disable iff (!nrst_in)
		(rd_in && !wr_in) |=> (irq_mask == $past(irq_mask)) &&
			(high_watermark == $past(high_watermark));
	endproperty
	a_read_quiet: assert property (p_read_quiet) // [R16]
		else $error("read changed control state");

	property p_high_band;
		@(posedge clk_in) disable iff (!nrst_in)
		(high_watermark >= `MARK_MIN) && (high_watermark <= HIGH_MAX) &&
			(low_watermark >= `MARK_MIN) && (low_watermark <= HIGH_MAX);
	endproperty
	a_high_band: assert property (p_high_band) // [R15]
		else $error("mark outside legal band");
endmodule

`default_nettype wire

// ---- hw/sticky_flag.sv ----
`timescale 1ns/1ps
`default_nettype none

// One sticky event bit; a set in the clearing cycle wins
module sticky_flag (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic set_in,
	input  wire logic clr_in,
	output var  logic flag_out
);
	logic next_flag;

	// Set has priority so no event is lost during a clear
	always_comb begin
		next_flag = set_in | (flag_out & ~clr_in);
	end

	// Flag register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flag_out <= 1'h0;
		end else begin
			flag_out <= next_flag;
		end
	end
endmodule

`default_nettype wire

// ---- tb/fifo_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_cfg.svh"

// Storage side of the FIFO: keeps occupancy, drops a write when full
module fifo_far_model (
	input  wire logic                clk_in,
	input  wire logic                nrst_in,
	input  wire logic                push_in,
	input  wire logic                pop_in,
	output var  fifo_ctl_pkg::word_t fill_out,
	output var  logic                wr_out,
	output var  logic                rd_out
);
	import fifo_ctl_pkg::*;
	// Strobes pass straight through so the block sees them in the same cycle
	assign wr_out = push_in;
	assign rd_out = pop_in;
	// Lost words never move the count, as in the real storage
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fill_out <= `WORD_ZERO;
		end else if (push_in && fill_out < `FIFO_DEPTH) begin
			fill_out <= fill_out + 32'h0000_0001;
		end else if (pop_in && fill_out != `WORD_ZERO) begin
			fill_out <= fill_out - 32'h0000_0001;
		end
	end
endmodule
`default_nettype wire

// ---- tb/fifo_status_event_irq_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_cfg.svh"

module fifo_status_event_irq_test;
	import fifo_ctl_pkg::*;
	logic      clk_in = 1'h0;
	logic      nrst_in = 1'h0;
	logic      push = 1'h0;
	logic      pop = 1'h0;
	logic      fifo_wr;
	logic      fifo_rd;
	logic      rd = 1'h0;
	logic      wr = 1'h0;
	reg_addr_t addr = 3'h0;
	word_t     wdata = 32'h0000_0000;
	word_t     fill;
	word_t     rdata;
	flags_t    live;
	logic      irq;
	word_t     exp;
	int        mismatches = 0;
	int        num_checks = 0;

	// Free-running 50 MHz clock
	always #10 clk_in = ~clk_in;

	fifo_far_model u_fifo_far_model (.clk_in(clk_in), .nrst_in(nrst_in),
		.push_in(push), .pop_in(pop), .fill_out(fill),
		.wr_out(fifo_wr), .rd_out(fifo_rd));

	fifo_status_event_irq u_fifo_status_event_irq (.clk_in(clk_in),
		.nrst_in(nrst_in), .fill_level_in(fill), .fifo_wr_in(fifo_wr),
		.fifo_rd_in(fifo_rd), .addr_in(addr), .rd_in(rd), .wr_in(wr),
		.wdata_in(wdata), .rdata_out(rdata), .live_flags_out(live),
		.irq_out(irq));

	task automatic check(input string name, input word_t seen,
		input word_t want);
		num_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One-cycle strobes; read data is taken one cycle after the strobe
	task automatic reg_wr(input reg_addr_t a, input word_t d);
		@(posedge clk_in);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		wr <= 1'h0;
	endtask

	task automatic reg_rd(input reg_addr_t a, input word_t want,
		input string name);
		@(posedge clk_in);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk_in);
		rd <= 1'h0;
		#1;
		check(name, rdata, want);
	endtask

	// Push or pop for n back-to-back cycles
	task automatic move(input logic p, input logic q, input int n);
		repeat (n) begin
			@(posedge clk_in);
			push <= p;
			pop <= q;
		end
		@(posedge clk_in);
		push <= 1'h0;
		pop <= 1'h0;
	endtask

	// Watchdog so a stuck run still reaches the verdict
	initial begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		print_verdict();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_in);
		check("irq", {31'h0000_0000, irq}, `WORD_ZERO);
		nrst_in <= 1'h1;
		reg_rd(`REG_STICKY, 32'h0000_0005, "sticky");
		reg_rd(`REG_MASK, `WORD_ZERO, "mask");
		reg_rd(`REG_HIGH, `FIFO_DEPTH - `GAP_DUAL, "high");
		reg_rd(`REG_LOW, `MARK_MIN, "low");
		move(1'h1, 1'h0, 10);
		reg_wr(`REG_STICKY, `WORD_ZERO);
		reg_rd(`REG_STICKY, 32'h0000_0005, "sticky");
		reg_rd(`REG_STICKY, 32'h0000_0005, "sticky");
		// Both marks clamped at both ends
		reg_wr(`REG_HIGH, `WORD_ZERO);
		reg_rd(`REG_HIGH, `MARK_MIN, "high");
		reg_wr(`REG_HIGH, 32'h0000_1000);
		reg_rd(`REG_HIGH, `FIFO_DEPTH - `GAP_DUAL, "high");
		reg_wr(`REG_LOW, `WORD_ZERO);
		reg_rd(`REG_LOW, `MARK_MIN, "low");
		reg_wr(`REG_LOW, 32'h0000_1000);
		reg_rd(`REG_LOW, `FIFO_DEPTH - `GAP_DUAL, "low");
		// Init: clear, mask, marks; a second clear drops leftovers
		reg_wr(`REG_STICKY, 32'h0000_003F);
		reg_wr(`REG_MASK, `WORD_ZERO);
		reg_wr(`REG_HIGH, 32'h0000_0014);
		reg_wr(`REG_LOW, 32'h0000_0005);
		reg_wr(`REG_STICKY, 32'h0000_003F);
		reg_rd(`REG_STICKY, `WORD_ZERO, "sticky");
		move(1'h1, 1'h0, 11);
		reg_rd(`REG_STICKY, 32'h0000_0008, "sticky");
		check("irq", {31'h0000_0000, irq}, `WORD_ZERO);
		reg_wr(`REG_STICKY, 32'h0000_0008);
		// Fill to the top, then one write too many
		move(1'h1, 1'h0, 236);
		reg_rd(`REG_FILL, `FIFO_DEPTH, "fill");
		check("live", {26'h000_0000, live}, 32'h0000_000A);
		reg_rd(`REG_STICKY, 32'h0000_001A, "sticky");
		reg_rd(`REG_LIVE, 32'h0000_000A, "live");
		reg_wr(`REG_STICKY, 32'h0000_003F);
		reg_rd(`REG_STICKY, 32'h0000_000A, "sticky");
		// Drain past empty, then one read too many
		move(1'h0, 1'h1, 257);
		reg_rd(`REG_STICKY, 32'h0000_002F, "sticky");
		// Each mask bit alone, the all-enable bit last
		for (int i = 0; i < 7; i++) begin
			reg_wr(`REG_MASK, 32'h0000_0001 << i);
			reg_rd(`REG_MASK, 32'h0000_0001 << i, "mask");
			exp = (i == `BIT_ALL) ? 32'h0000_0001 :
				(32'h0000_002F >> i) & 32'h0000_0001;
			check("irq", {31'h0000_0000, irq}, exp);
		end
		reg_wr(`REG_MASK, `WORD_ZERO);
		reg_rd(`REG_MASK, `WORD_ZERO, "mask");
		check("irq", {31'h0000_0000, irq}, `WORD_ZERO);
		// Mid-run reset with every mask bit set must wipe mask and irq
		reg_wr(`REG_MASK, 32'h0000_007F);
		@(posedge clk_in);
		nrst_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		check("irq", {31'h0000_0000, irq}, `WORD_ZERO);
		nrst_in <= 1'h1;
		reg_rd(`REG_MASK, `WORD_ZERO, "mask");
		reg_rd(`REG_STICKY, 32'h0000_0005, "sticky");
		reg_rd(`REG_HIGH, `FIFO_DEPTH - `GAP_DUAL, "high");
		// Unmapped and read-only places ignore writes
		reg_wr(3'h6, 32'hFFFF_FFFF);
		reg_rd(3'h6, `WORD_ZERO, "unmapped");
		reg_wr(`REG_FILL, 32'h0000_0055);
		reg_rd(`REG_FILL, `WORD_ZERO, "fill");
		print_verdict();
	end
endmodule
`default_nettype wire
